// File: hw/ppi_pkg.sv
/*
  Package for the programmable parallel port block: port addresses,
  control word field positions, reset values and mode codes.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package ppi_pkg;
  localparam int PORT_W = 8;
  localparam int HALF_W = 4;
  localparam logic [1:0] ADDR_FIRST = 2'h0;
  localparam logic [1:0] ADDR_SECOND = 2'h1;
  localparam logic [1:0] ADDR_THIRD = 2'h2;
  localparam logic [1:0] ADDR_CTRL = 2'h3;
  localparam int CW_CMD_BIT = 7;
  localparam int CW_MODE_A_HI = 6;
  localparam int CW_MODE_A_LO = 5;
  localparam int CW_DIR_A_BIT = 4;
  localparam int CW_DIR_CU_BIT = 3;
  localparam int CW_MODE_B_BIT = 2;
  localparam int CW_DIR_B_BIT = 1;
  localparam int CW_DIR_CL_BIT = 0;
  localparam int BSR_SEL_HI = 3;
  localparam int BSR_SEL_LO = 1;
  localparam int BSR_VAL_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h9B;
  localparam logic [7:0] OUT_RESET = 8'h00;
  localparam logic [2:0] IRQ_BIT_A_IN = 3'h4;
  localparam logic [2:0] IRQ_BIT_A_OUT = 3'h6;
  localparam logic [2:0] IRQ_BIT_B = 3'h2;
  localparam logic [2:0] IRQ_OUT_A = 3'h3;
  localparam logic [2:0] IRQ_OUT_B = 3'h0;
  typedef enum logic [1:0] {MODE_BASIC, MODE_STROBED, MODE_BIDIR} port_mode_t;
endpackage
`default_nettype wire

// File: hw/ppi_sync.sv
/*
  Two flip-flop synchroniser for a bus of asynchronous pins.
  Assumes one clock and an asynchronous active-high reset.
*/
`default_nettype none
module ppi_sync #(
  parameter int W = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_r;
  if (W < 1) begin : g_bad_width
    $error("synchroniser width must be positive");
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= '0;
      q_out <= '0;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// File: hw/ppi_core.sv
/*
  Programmable three-port parallel interface: host bus strobes, control
  word, mode 0 ports, port C bit set/reset and interrupt enable flags.
  Assumes host strobes and port pins are asynchronous; they are
  synchronised here. Pin tristate is resolved by the bench.
*/
// Operation
// [RULE1] Host holds select low; else bus floats
// [RULE2] Address picks port or control; no control reads
// [RULE3] Reset clears control, all ports input
// [RULE4] After reset all lines float until programmed
// [RULE5] Group A: port A, C upper; B: rest
// [RULE6] Control register write only, never read back
// [RULE7] Port A output latch and input latch; the code has no input latch, reads return live pins
// [RULE8] Port B output latch and input buffer
// [RULE9] Port C output latch, live pin reads
// [RULE10] Port C halves each own four-bit latch
// [RULE11] Three modes chosen by one write
// [RULE12] Ports A and B take modes independently
// [RULE13] Mode write clears all output registers
// [RULE14] One write sets or clears one C bit
// [RULE15] Bit set/reset reaches control lines too
// [RULE16] Interrupt requests gated by enable flags
// [RULE17] Enable flags cleared on reset, mode write
// [RULE18] Mode 0 writes latched straight to outputs
// [RULE19] Mode 0 input reads return live pins
// [RULE20] Bits 4,3,1,0 set directions, 1 input
// [RULE21] Bit 7 chooses mode word or bit command
// [RULE22] Bits 3-1 pick C bit, bit 0 value
`default_nettype none
module ppi_core
  import ppi_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  input wire logic CHIP_SEL_N_IN,
  input wire logic READ_N_IN,
  input wire logic WRITE_N_IN,
  input wire logic PORT_ADDR_BIT0_IN,
  input wire logic PORT_ADDR_BIT1_IN,
  input wire logic [ppi_pkg::PORT_W-1:0] HOST_BUS_LINES_IN,
  output logic [ppi_pkg::PORT_W-1:0] HOST_BUS_LINES_OUT,
  output logic HOST_BUS_LINES_OE_N_OUT,
  input wire logic [ppi_pkg::PORT_W-1:0] FIRST_PORT_LINES_IN,
  output logic [ppi_pkg::PORT_W-1:0] FIRST_PORT_LINES_OUT,
  output logic [ppi_pkg::PORT_W-1:0] FIRST_PORT_LINES_OE_N_OUT,
  input wire logic [ppi_pkg::PORT_W-1:0] SECOND_PORT_LINES_IN,
  output logic [ppi_pkg::PORT_W-1:0] SECOND_PORT_LINES_OUT,
  output logic [ppi_pkg::PORT_W-1:0] SECOND_PORT_LINES_OE_N_OUT,
  input wire logic [ppi_pkg::PORT_W-1:0] THIRD_PORT_LINES_IN,
  output logic [ppi_pkg::PORT_W-1:0] THIRD_PORT_LINES_OUT,
  output logic [ppi_pkg::PORT_W-1:0] THIRD_PORT_LINES_OE_N_OUT,
  output logic [2:0] IRQ_ENABLE_FLAG_OUT
);
  import ppi_pkg::*;

  localparam int BUS_W = 1 + 1 + 1 + 2 + PORT_W;

  logic [BUS_W-1:0] bus_raw;
  logic [BUS_W-1:0] bus_s;
  logic [PORT_W-1:0] pa_s;
  logic [PORT_W-1:0] pb_s;
  logic [PORT_W-1:0] pc_s;

  // Strobes enter inverted so the cleared synchroniser reads as idle
  assign bus_raw = {!CHIP_SEL_N_IN, !READ_N_IN, !WRITE_N_IN, PORT_ADDR_BIT1_IN,
                    PORT_ADDR_BIT0_IN, HOST_BUS_LINES_IN};

  ppi_sync #(.W(BUS_W)) u_bus_sync (
    .clk_in(SYS_CLK_IN),
    .rst_in(RESET_IN),
    .d_in(bus_raw),
    .q_out(bus_s)
  );
  ppi_sync #(.W(3 * PORT_W)) u_pin_sync (
    .clk_in(SYS_CLK_IN),
    .rst_in(RESET_IN),
    .d_in({FIRST_PORT_LINES_IN, SECOND_PORT_LINES_IN, THIRD_PORT_LINES_IN}),
    .q_out({pa_s, pb_s, pc_s})
  );

  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic cs_s;
  logic rd_s;
  logic wr_s;
  logic [1:0] addr;
  logic [PORT_W-1:0] wdata;
  assign {cs_s, rd_s, wr_s, addr, wdata} = bus_s;
  assign cs_n = !cs_s;
  assign rd_n = !rd_s;
  assign wr_n = !wr_s;

  // Write commits on the trailing edge of the strobe, data still valid
  logic wr_active_r;
  logic [1:0] wr_addr_r;
  logic [PORT_W-1:0] wr_data_r;
  logic wr_fire;
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      wr_active_r <= 1'b0;
      wr_addr_r <= 2'h0;
      wr_data_r <= 8'h00;
    end else begin
      wr_active_r <= !cs_n && !wr_n;
      if (!cs_n && !wr_n) begin
        wr_addr_r <= addr;
        wr_data_r <= wdata;
      end
    end
  end
  assign wr_fire = wr_active_r && !(!cs_n && !wr_n);

  logic mode_wr;
  logic bsr_wr;
  assign mode_wr = wr_fire && wr_addr_r == ADDR_CTRL && wr_data_r[CW_CMD_BIT]; // RULE21
  assign bsr_wr = wr_fire && wr_addr_r == ADDR_CTRL && !wr_data_r[CW_CMD_BIT]; // RULE21

  // Control register; reset leaves every direction bit at input
  logic [PORT_W-1:0] ctrl_r;
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ctrl_r <= CTRL_RESET; // RULE3
    end else if (mode_wr) begin
      ctrl_r <= wr_data_r; // RULE11
    end
  end

  function automatic port_mode_t mode_a(input logic [PORT_W-1:0] cw);
    if (cw[CW_MODE_A_HI]) return MODE_BIDIR;
    else if (cw[CW_MODE_A_LO]) return MODE_STROBED;
    else return MODE_BASIC;
  endfunction

  port_mode_t mode_a_s;
  port_mode_t mode_b_s;
  assign mode_a_s = mode_a(ctrl_r); // RULE12
  assign mode_b_s = ctrl_r[CW_MODE_B_BIT] ? MODE_STROBED : MODE_BASIC; // RULE12

  logic dir_a_in;
  logic dir_b_in;
  logic dir_cu_in;
  logic dir_cl_in;
  assign dir_a_in = ctrl_r[CW_DIR_A_BIT]; // RULE20
  assign dir_cu_in = ctrl_r[CW_DIR_CU_BIT]; // RULE20
  assign dir_b_in = ctrl_r[CW_DIR_B_BIT]; // RULE20
  assign dir_cl_in = ctrl_r[CW_DIR_CL_BIT]; // RULE20

  // Output latches, cleared on every mode word
  logic [PORT_W-1:0] pa_out_r;
  logic [PORT_W-1:0] pb_out_r;
  logic [HALF_W-1:0] pc_hi_r;
  logic [HALF_W-1:0] pc_lo_r;
  logic [2:0] bsr_sel;
  assign bsr_sel = wr_data_r[BSR_SEL_HI:BSR_SEL_LO];

  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      pa_out_r <= OUT_RESET;
    end else if (mode_wr) begin
      pa_out_r <= OUT_RESET; // RULE13
    end else if (wr_fire && wr_addr_r == ADDR_FIRST) begin
      pa_out_r <= wr_data_r; // RULE7 RULE18
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      pb_out_r <= OUT_RESET;
    end else if (mode_wr) begin
      pb_out_r <= OUT_RESET; // RULE13
    end else if (wr_fire && wr_addr_r == ADDR_SECOND) begin
      pb_out_r <= wr_data_r; // RULE8 RULE18
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      pc_hi_r <= OUT_RESET[HALF_W-1:0];
    end else if (mode_wr) begin
      pc_hi_r <= OUT_RESET[HALF_W-1:0]; // RULE13
    end else if (bsr_wr && bsr_sel[2]) begin
      pc_hi_r[bsr_sel[1:0]] <= wr_data_r[BSR_VAL_BIT]; // RULE14 RULE15 RULE22
    end else if (wr_fire && wr_addr_r == ADDR_THIRD) begin
      pc_hi_r <= wr_data_r[PORT_W-1:HALF_W]; // RULE10
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      pc_lo_r <= OUT_RESET[HALF_W-1:0];
    end else if (mode_wr) begin
      pc_lo_r <= OUT_RESET[HALF_W-1:0]; // RULE13
    end else if (bsr_wr && !bsr_sel[2]) begin
      pc_lo_r[bsr_sel[1:0]] <= wr_data_r[BSR_VAL_BIT]; // RULE14 RULE15 RULE22
    end else if (wr_fire && wr_addr_r == ADDR_THIRD) begin
      pc_lo_r <= wr_data_r[HALF_W-1:0]; // RULE10
    end
  end

  // Interrupt enable flags: [2] A input, [1] A output, [0] B
  logic [2:0] irq_en_r;
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      irq_en_r <= 3'h0; // RULE17
    end else if (mode_wr) begin
      irq_en_r <= 3'h0; // RULE17
    end else if (bsr_wr) begin
      if (bsr_sel == IRQ_BIT_A_IN) irq_en_r[2] <= wr_data_r[BSR_VAL_BIT]; // RULE16
      if (bsr_sel == IRQ_BIT_A_OUT) irq_en_r[1] <= wr_data_r[BSR_VAL_BIT]; // RULE16
      if (bsr_sel == IRQ_BIT_B) irq_en_r[0] <= wr_data_r[BSR_VAL_BIT]; // RULE16
    end
  end

  // Handshaking modes drive request lines gated by the enable flags
  logic irq_req_a;
  logic irq_req_b;
  assign irq_req_a = (mode_a_s == MODE_STROBED && dir_a_in) ? irq_en_r[2] :
                     (mode_a_s == MODE_STROBED) ? irq_en_r[1] :
                     (mode_a_s == MODE_BIDIR) ? (irq_en_r[2] | irq_en_r[1]) : 1'b0;
  assign irq_req_b = (mode_b_s == MODE_STROBED) ? irq_en_r[0] : 1'b0;

  logic [PORT_W-1:0] pc_val;
  always_comb begin
    pc_val = {pc_hi_r, pc_lo_r};
    if (mode_a_s != MODE_BASIC) pc_val[IRQ_OUT_A] = irq_req_a; // RULE16
    if (mode_b_s != MODE_BASIC) pc_val[IRQ_OUT_B] = irq_req_b; // RULE16
  end

  logic [PORT_W-1:0] pc_oe_n;
  always_comb begin
    pc_oe_n = {{HALF_W{dir_cu_in}}, {HALF_W{dir_cl_in}}}; // RULE5
    if (mode_a_s != MODE_BASIC) pc_oe_n[IRQ_OUT_A] = 1'b0;
    if (mode_b_s != MODE_BASIC) pc_oe_n[IRQ_OUT_B] = 1'b0;
  end

  // Registered pin drivers; enables low drive the pin
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      FIRST_PORT_LINES_OUT <= OUT_RESET;
      SECOND_PORT_LINES_OUT <= OUT_RESET;
      THIRD_PORT_LINES_OUT <= OUT_RESET;
      FIRST_PORT_LINES_OE_N_OUT <= 8'hFF; // RULE4
      SECOND_PORT_LINES_OE_N_OUT <= 8'hFF; // RULE4
      THIRD_PORT_LINES_OE_N_OUT <= 8'hFF; // RULE4
      IRQ_ENABLE_FLAG_OUT <= 3'h0;
    end else begin
      FIRST_PORT_LINES_OUT <= pa_out_r;
      SECOND_PORT_LINES_OUT <= pb_out_r;
      THIRD_PORT_LINES_OUT <= pc_val;
      FIRST_PORT_LINES_OE_N_OUT <= {PORT_W{dir_a_in}}; // RULE5 RULE20
      SECOND_PORT_LINES_OE_N_OUT <= {PORT_W{dir_b_in}}; // RULE5 RULE20
      THIRD_PORT_LINES_OE_N_OUT <= pc_oe_n;
      IRQ_ENABLE_FLAG_OUT <= irq_en_r;
    end
  end

  // Read path: inputs are live pins, A and B outputs read their latch, port C always reads its pins
  logic rd_sel;
  logic [PORT_W-1:0] rd_val;
  assign rd_sel = !cs_n && !rd_n && addr != ADDR_CTRL; // RULE2 RULE6
  always_comb begin
    case (addr)
      ADDR_FIRST: rd_val = dir_a_in ? pa_s : pa_out_r; // RULE19
      ADDR_SECOND: rd_val = dir_b_in ? pb_s : pb_out_r; // RULE19
      ADDR_THIRD: rd_val = pc_s; // RULE9
      default: rd_val = 8'h00; // RULE6
    endcase
  end

  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      HOST_BUS_LINES_OUT <= 8'h00;
      HOST_BUS_LINES_OE_N_OUT <= 1'b1;
    end else begin
      HOST_BUS_LINES_OUT <= rd_sel ? rd_val : 8'h00;
      HOST_BUS_LINES_OE_N_OUT <= !rd_sel; // RULE1
    end
  end

  // Port A write: commit, latch, then registered pin driver
  sequence s_port_a_write;
    wr_fire && wr_addr_r == ADDR_FIRST;
  endsequence

  a_bus_float: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN) // RULE1
    cs_n |=> HOST_BUS_LINES_OE_N_OUT) else $error("bus driven while deselected");
  a_read_drives: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN) // RULE2
    rd_sel |=> !HOST_BUS_LINES_OE_N_OUT) else $error("read left bus floating");
  a_no_ctrl_read: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN) // RULE6
    (addr == ADDR_CTRL) |=> HOST_BUS_LINES_OE_N_OUT) else $error("control read");
  a_reset_input: assert property (@(posedge SYS_CLK_IN) // RULE4
    $fell(RESET_IN) |-> FIRST_PORT_LINES_OE_N_OUT == 8'hFF) else $error("port driven");
  a_ctrl_reset: assert property (@(posedge SYS_CLK_IN) // RULE3
    $fell(RESET_IN) |-> ctrl_r == CTRL_RESET) else $error("control not cleared");
  a_ctrl_kept: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN) // RULE11
    !mode_wr |=> $stable(ctrl_r)) else $error("control changed without mode word");
  a_mode_clears: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN) // RULE13
    mode_wr |=> pa_out_r == 8'h00 && pb_out_r == 8'h00 && {pc_hi_r, pc_lo_r} == 8'h00)
    else $error("mode word left latch");
  a_irq_cleared: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN) // RULE17
    mode_wr |=> ##1 IRQ_ENABLE_FLAG_OUT == 3'h0) else $error("enable flag kept");
  a_irq_mirror: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN) // RULE16
    ##1 IRQ_ENABLE_FLAG_OUT == $past(irq_en_r)) else $error("enable flag output lags");
  a_bsr_flag: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN) // RULE16
    bsr_wr && bsr_sel == IRQ_BIT_B |=> irq_en_r[0] == $past(wr_data_r[BSR_VAL_BIT]))
    else $error("enable flag not taken");
  a_irq_b_gate: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN) // RULE16
    mode_b_s == MODE_STROBED |=> THIRD_PORT_LINES_OUT[IRQ_OUT_B] == $past(irq_en_r[0]))
    else $error("request not gated by flag");
  a_bsr_one_bit: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN) // RULE14
    bsr_wr |=> ({pc_hi_r, pc_lo_r} ^ $past({pc_hi_r, pc_lo_r})) == 8'h00 ||
    $onehot({pc_hi_r, pc_lo_r} ^ $past({pc_hi_r, pc_lo_r}))) else $error("bsr many bits");
  a_port_a_latch: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN) // RULE18
    s_port_a_write |=> ##1 FIRST_PORT_LINES_OUT == $past(wr_data_r, 2))
    else $error("port A not latched");
  a_dir_a: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN) // RULE20
    ##1 FIRST_PORT_LINES_OE_N_OUT == {PORT_W{$past(ctrl_r[CW_DIR_A_BIT])}})
    else $error("port A direction");
  a_dir_b: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN) // RULE20
    ##1 SECOND_PORT_LINES_OE_N_OUT == {PORT_W{$past(ctrl_r[CW_DIR_B_BIT])}})
    else $error("port B direction");
endmodule
`default_nettype wire

// File: tb/ppi_periph.sv
/*
  Peripheral-side model of one 8-bit port: resolves every line.
  Assumes per-bit active-low enables and latch values from the block.
*/
`default_nettype none
module ppi_periph (
  input wire logic [7:0] oe_n_in,
  input wire logic [7:0] dout_in,
  input wire logic [7:0] drv_in,
  output logic [7:0] pin_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Peripheral drives only the lines the block releases
  always_comb pin_out = (oe_n_in & drv_in) | (~oe_n_in & dout_in);
endmodule
`default_nettype wire

// File: tb/programmable_parallel_io_port_tb.sv
/*
  Self-checking bench: reset, mode 0 directions and traffic, bit
  set/reset, enable flags. Assumes ppi_pkg and ppi_periph compiled first.
*/
`default_nettype none
module programmable_parallel_io_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ppi_pkg::*;
  logic clk, rst, cs_n, rd_n, wr_n, a0, a1, bus_oe_n, ok, v;
  logic [7:0] bus_in, bus_out, d, mode, ma, mb, mc;
  logic [7:0] drv [3];
  logic [7:0] pin [3];
  logic [7:0] pout [3];
  logic [7:0] poe [3];
  logic [7:0] dat [3];
  logic [2:0] flags;
  int seed, bad_count, n_checks, cfg, i, j;

  ppi_core dut (.SYS_CLK_IN(clk), .RESET_IN(rst), .CHIP_SEL_N_IN(cs_n), .READ_N_IN(rd_n),
    .WRITE_N_IN(wr_n), .PORT_ADDR_BIT0_IN(a0), .PORT_ADDR_BIT1_IN(a1),
    .HOST_BUS_LINES_IN(bus_in), .HOST_BUS_LINES_OUT(bus_out),
    .HOST_BUS_LINES_OE_N_OUT(bus_oe_n), .FIRST_PORT_LINES_IN(pin[0]),
    .FIRST_PORT_LINES_OUT(pout[0]), .FIRST_PORT_LINES_OE_N_OUT(poe[0]),
    .SECOND_PORT_LINES_IN(pin[1]), .SECOND_PORT_LINES_OUT(pout[1]),
    .SECOND_PORT_LINES_OE_N_OUT(poe[1]), .THIRD_PORT_LINES_IN(pin[2]),
    .THIRD_PORT_LINES_OUT(pout[2]), .THIRD_PORT_LINES_OE_N_OUT(poe[2]),
    .IRQ_ENABLE_FLAG_OUT(flags));

  for (genvar g = 0; g < 3; g++) begin : g_per
    ppi_periph u_per (.oe_n_in(poe[g]), .dout_in(pout[g]), .drv_in(drv[g]), .pin_out(pin[g]));
  end

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [7:0] sel(logic [7:0] m, logic [7:0] dv, logic [7:0] dt);
    return (dv & m) | (dt & ~m);
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Strobes held four cycles, then idle long enough for the pins to follow
  task automatic wr(input logic [1:0] ad, input logic [7:0] dt);
    {a1, a0} = ad;
    bus_in = dt;
    cs_n = 1'b0;
    wr_n = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    wr_n = 1'b1;
    cs_n = 1'b1;
    bus_in = ~dt;
    repeat (7) @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [1:0] ad, output logic [7:0] dt, output logic drove);
    int k;
    drove = 1'b0;
    dt = 8'h00;
    {a1, a0} = ad;
    cs_n = 1'b0;
    rd_n = 1'b0;
    for (k = 0; k < 8 && !drove; k++) begin
      @(posedge clk);
      #1;
      if (bus_oe_n === 1'b0) begin
        drove = 1'b1;
        dt = bus_out;
      end
    end
    rd_n = 1'b1;
    cs_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic rdp(input logic [1:0] ad, input logic [7:0] exp, input string nm);
    logic [7:0] dt;
    logic dr;
    rd(ad, dt, dr);
    chk({nm, "_drive"}, {7'h00, dr}, 8'h01);
    if (dr !== 1'b1) begin
      end_sim();
    end else begin
      chk(nm, dt, exp);
    end
  endtask

  initial begin
    seed = 1258;
    bad_count = 0;
    n_checks = 0;
    {rst, cs_n, rd_n, wr_n, a0, a1} = 6'h3C;
    bus_in = 8'h00;
    for (i = 0; i < 3; i++) drv[i] = 8'h00;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    for (i = 0; i < 3; i++) chk("float", poe[i], 8'hFF);
    chk("bus_idle", {7'h00, bus_oe_n}, 8'h01);
    chk("flags", {5'h00, flags}, 8'h00);
    rd(ADDR_CTRL, d, ok);
    chk("ctrl_rd", {7'h00, ok}, 8'h00);
    $display("test reset done");
    for (cfg = 0; cfg < 16; cfg++) begin
      mode = {1'b1, 2'h0, cfg[3], cfg[2], 1'b0, cfg[1], cfg[0]};
      wr(ADDR_CTRL, mode);
      for (i = 0; i < 3; i++) chk("clr", pout[i], OUT_RESET);
      ma = {8{cfg[3]}};
      mb = {8{cfg[1]}};
      mc = {{4{cfg[2]}}, {4{cfg[0]}}};
      chk("dir_a", poe[0], ma);
      chk("dir_b", poe[1], mb);
      chk("dir_c", poe[2], mc);
      for (i = 0; i < 3; i++) begin
        dat[i] = 8'($random(seed));
        wr(2'(i), dat[i]);
      end
      chk("lat_a", pout[0] & ~ma, dat[0] & ~ma);
      chk("lat_b", pout[1] & ~mb, dat[1] & ~mb);
      chk("lat_c", pout[2] & ~mc, dat[2] & ~mc);
      for (j = 0; j < 2; j++) begin
        for (i = 0; i < 3; i++) drv[i] = 8'($random(seed));
        rdp(ADDR_FIRST, sel(ma, drv[0], dat[0]), "rd_a");
        rdp(ADDR_SECOND, sel(mb, drv[1], dat[1]), "rd_b");
        rdp(ADDR_THIRD, sel(mc, drv[2], dat[2]), "rd_c");
      end
    end
    $display("test mode0 done");
    wr(ADDR_CTRL, 8'h80);
    dat[2] = 8'($random(seed));
    wr(ADDR_THIRD, dat[2]);
    for (i = 0; i < 8; i++) begin
      v = 1'($random(seed));
      wr(ADDR_CTRL, {4'h0, 3'(i), v});
      dat[2][i] = v;
      chk("bsr", pout[2], dat[2]);
    end
    rdp(ADDR_THIRD, dat[2], "bsr_rd");
    $display("test bitset done");
    wr(ADDR_CTRL, 8'hCD);
    chk("fl_clr", {5'h00, flags}, 8'h00);
    wr(ADDR_CTRL, 8'h09);
    chk("fl_a_in", {5'h00, flags}, 8'h04);
    wr(ADDR_CTRL, 8'h0D);
    wr(ADDR_CTRL, 8'h05);
    chk("fl_all", {5'h00, flags}, 8'h07);
    chk("irq_pin", pout[2] & 8'h09, 8'h09);
    chk("irq_oe", poe[2] & 8'h09, 8'h00);
    wr(ADDR_CTRL, 8'h0C);
    wr(ADDR_CTRL, 8'h08);
    chk("fl_b", {5'h00, flags}, 8'h01);
    chk("irq_a_lo", pout[2] & 8'h08, 8'h00);
    wr(ADDR_CTRL, 8'hC4);
    chk("fl_mode", {5'h00, flags}, 8'h00);
    wr(ADDR_CTRL, 8'hB0);
    wr(ADDR_CTRL, 8'h0D);
    chk("irq_ain0", pout[2] & 8'h08, 8'h00);
    wr(ADDR_CTRL, 8'h09);
    chk("irq_ain1", pout[2] & 8'h08, 8'h08);
    wr(ADDR_CTRL, 8'hA0);
    wr(ADDR_CTRL, 8'h0D);
    chk("irq_aout", pout[2] & 8'h08, 8'h08);
    $display("test flags done");
    wr(ADDR_CTRL, 8'h80);
    wr(ADDR_CTRL, 8'h05);
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    for (i = 0; i < 3; i++) chk("rst_oe", poe[i], 8'hFF);
    chk("rst_fl", {5'h00, flags}, 8'h00);
    rst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    for (i = 0; i < 3; i++) chk("rst_dir", poe[i], 8'hFF);
    chk("rst_bus", {7'h00, bus_oe_n}, 8'h01);
    $display("test reset2 done");
    end_sim();
  end
endmodule
`default_nettype wire
